// ==== verilog/urf_pkg.sv ====
/*
 * Constants, state types and shared decode functions for the serial channel datapath.
 * Assumes a 32-bit APB slave with byte addresses on word boundaries and one clock.
 */
package urf_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
	localparam logic [7:0] OFS_INT_CAUSE = 8'h08;
	localparam logic [7:0] OFS_FIFO_CTL = 8'h0C;
	localparam logic [7:0] OFS_LINE_FMT = 8'h10;
	localparam logic [7:0] OFS_LINE_STATE = 8'h14;
	localparam logic [7:0] OFS_FRAC_DIV = 8'h18;
	localparam logic [7:0] OFS_BAUD_DIV = 8'h1C;

	// FIFO geometry
	localparam logic [5:0] DEPTH = 6'h20;
	localparam int RX_W = 11;

	// Field positions
	localparam int FC_FIFO_EN = 0;
	localparam int FC_RXTRIG_LSB = 1;
	localparam int FC_TXTRIG_LSB = 3;
	localparam int LF_WLEN_LSB = 0;
	localparam int LF_STOP2 = 2;
	localparam int LF_PAR_EN = 3;
	localparam int LF_PAR_EVEN = 4;
	localparam int FD_OS_LSB = 4;
	localparam int LS_READY = 0;
	localparam int LS_OVERRUN = 1;
	localparam int LS_PARITY = 2;
	localparam int LS_FRAMING = 3;
	localparam int LS_BREAK = 4;
	localparam int LS_HOLD_EMPTY = 5;
	localparam int LS_ALL_EMPTY = 6;
	localparam int IC_RX = 0;
	localparam int IC_TX = 1;
	localparam int IC_TIMEOUT = 2;

	// Reset values
	localparam logic [4:0] RST_FIFO_CTL = 5'h00;
	localparam logic [4:0] RST_LINE_FMT = 5'h03;
	localparam logic [1:0] RST_OS_SEL = 2'h0;
	localparam logic [15:0] RST_BAUD_DIV = 16'h0001;
	localparam logic [2:0] RST_INT_ENABLE = 3'h0;

	// Timing counts in oversampling clocks and bit times
	localparam logic [4:0] OS_16X = 5'h10;
	localparam logic [4:0] OS_8X = 5'h08;
	localparam logic [4:0] OS_4X = 5'h04;
	localparam logic [5:0] TO_WORDS = 6'h04;
	localparam logic [5:0] TO_EXTRA = 6'h0C;
	localparam logic [3:0] WLEN_BASE = 4'h5;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b011,
		ST_PARITY = 3'b010,
		ST_STOP = 3'b110
	} urf_state_t;

	function automatic logic [4:0] os_len(input logic [1:0] sel);
		os_len = (sel == 2'h0) ? OS_16X : ((sel == 2'h1) ? OS_8X : OS_4X);
	endfunction : os_len

	function automatic logic [5:0] trig_level(input logic [1:0] sel);
		case (sel)
			2'h0: trig_level = 6'h08;
			2'h1: trig_level = 6'h10;
			2'h2: trig_level = 6'h18;
			default: trig_level = 6'h1C;
		endcase
	endfunction : trig_level

	function automatic logic [7:0] data_mask(input logic [1:0] wsel);
		data_mask = 8'hFF >> (2'h3 - wsel);
	endfunction : data_mask

endpackage : urf_pkg

// ==== verilog/urf_fifo_if.sv ====
/*
 * Interface between the channel core and one of its FIFOs.
 * Assumes the FIFO owner drives head data and fill count combinationally from its state.
 */
`timescale 1ns/100ps
interface urf_fifo_if #(parameter int W = 8);
	logic push;
	logic [W-1:0] wdata;
	logic pop;
	logic flush;
	logic [W-1:0] rdata;
	logic [5:0] count;

	modport store (input push, input wdata, input pop, input flush, output rdata, output count);
	modport user (output push, output wdata, output pop, output flush, input rdata, input count);
endinterface : urf_fifo_if

// ==== verilog/urf_fifo.sv ====
/*
 * 32-entry synchronous FIFO with head presented combinationally.
 * Assumes the user never pushes when full or pops when empty; both are ignored here anyway.
 */
`timescale 1ns/100ps
module urf_fifo #(parameter int W = 8)
(
	input wire logic pclk,
	input wire logic presetn,
	urf_fifo_if.store f
);
	logic [W-1:0] mem [0:31];
	logic [4:0] wp_q;
	logic [4:0] rp_q;
	logic [5:0] cnt_q;
	wire do_push = f.push && (cnt_q != urf_pkg::DEPTH);
	wire do_pop = f.pop && (cnt_q != 6'h00);

	// Storage has no reset; only pointers define validity
	always_ff @(posedge pclk)
	begin
		if (do_push)
			mem[wp_q] <= f.wdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp_q <= 5'h00;
			rp_q <= 5'h00;
			cnt_q <= 6'h00;
		end
		else if (f.flush)
		begin
			wp_q <= 5'h00;
			rp_q <= 5'h00;
			cnt_q <= 6'h00;
		end
		else
		begin
			wp_q <= wp_q + 5'(do_push);
			rp_q <= rp_q + 5'(do_pop);
			cnt_q <= cnt_q + 6'(do_push) - 6'(do_pop);
		end
	end

	assign f.rdata = mem[rp_q];
	assign f.count = cnt_q;
endmodule : urf_fifo

// ==== verilog/urf_uart.sv ====
/*
 * Serial channel datapath: APB registers, transmit and receive shifters, two FIFOs, interrupts.
 * Assumes one 200 MHz clock, an asynchronous receive pin and a peer framed the same way.
 */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module urf_uart
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic irq
);
	// Control registers
	logic [4:0] fifo_control_q;
	logic [4:0] line_format_control_q;
	logic [1:0] os_sel_q;
	logic [15:0] baud_div_q;
	logic [2:0] interrupt_enable_reg_q;
	logic [2:0] interrupt_cause_q;
	logic [2:0] interrupt_cause_d;
	logic overrun_q;

	// Bus answer registers
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	// Oversampling tick
	logic [15:0] div_cnt_q;

	// Transmitter
	urf_pkg::urf_state_t tx_state_q;
	logic [7:0] tx_shifter_q;
	logic [2:0] tx_bit_q;
	logic [4:0] tx_sub_q;
	logic tx_parity_q;
	logic tx_stop2_q;
	logic txd_q;

	// Receiver
	logic rx_s1_q;
	logic rx_s2_q;
	logic rx_s3_q;
	urf_pkg::urf_state_t rx_state_q;
	logic [7:0] rx_shifter_q;
	logic [2:0] rx_bit_q;
	logic [4:0] rx_sub_q;
	logic rx_perr_q;
	logic [4:0] to_sub_q;
	logic [5:0] to_bits_q;
	logic to_done_q;

	urf_fifo_if #(.W(8)) txf ();
	urf_fifo_if #(.W(urf_pkg::RX_W)) rxf ();

	urf_fifo #(.W(8)) u_tx_fifo
	(
		.pclk(pclk),
		.presetn(presetn),
		.f(txf.store)
	);

	urf_fifo #(.W(urf_pkg::RX_W)) u_rx_fifo
	(
		.pclk(pclk),
		.presetn(presetn),
		.f(rxf.store)
	);

	// Configuration decode
	wire fifo_en = fifo_control_q[urf_pkg::FC_FIFO_EN];
	wire [1:0] rx_trig_sel = fifo_control_q[urf_pkg::FC_RXTRIG_LSB +: 2];
	wire [1:0] tx_trig_sel = fifo_control_q[urf_pkg::FC_TXTRIG_LSB +: 2];
	wire [1:0] wsel = line_format_control_q[urf_pkg::LF_WLEN_LSB +: 2];
	wire stop2 = line_format_control_q[urf_pkg::LF_STOP2];
	wire par_en = line_format_control_q[urf_pkg::LF_PAR_EN];
	wire par_even = line_format_control_q[urf_pkg::LF_PAR_EVEN];
	wire [4:0] bit_len = urf_pkg::os_len(os_sel_q);
	wire [4:0] half_len = bit_len >> 1;
	wire [2:0] last_bit = 3'(urf_pkg::WLEN_BASE + 4'(wsel) - 4'h1);
	wire [7:0] wmask = urf_pkg::data_mask(wsel);
	// Non-FIFO mode keeps the same storage but limits it to one entry
	wire [5:0] fill_limit = fifo_en ? urf_pkg::DEPTH : 6'h01;
	wire os_tick = (div_cnt_q == baud_div_q);

	// APB decode; every access takes one wait state so outputs stay registered
	wire pready_d = psel && penable && !pready_q;
	wire acc = psel && penable && pready_q;
	wire hit_data = (paddr == urf_pkg::OFS_DATA);
	wire hit_ien = (paddr == urf_pkg::OFS_INT_ENABLE);
	wire hit_icause = (paddr == urf_pkg::OFS_INT_CAUSE);
	wire hit_fctl = (paddr == urf_pkg::OFS_FIFO_CTL);
	wire hit_lfmt = (paddr == urf_pkg::OFS_LINE_FMT);
	wire hit_lstate = (paddr == urf_pkg::OFS_LINE_STATE);
	wire hit_fdiv = (paddr == urf_pkg::OFS_FRAC_DIV);
	wire hit_bdiv = (paddr == urf_pkg::OFS_BAUD_DIV);
	wire mapped = hit_data | hit_ien | hit_icause | hit_fctl | hit_lfmt | hit_lstate | hit_fdiv | hit_bdiv;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;

	// Line state view
	wire rx_ready = (rxf.count != 6'h00);
	wire hold_empty = (txf.count == 6'h00);
	wire all_empty = hold_empty && (tx_state_q == urf_pkg::ST_IDLE);
	wire [2:0] head_tags = rx_ready ? rxf.rdata[10:8] : 3'h0;
	logic [7:0] line_state;
	always_comb
	begin
		line_state = 8'h00;
		line_state[urf_pkg::LS_READY] = rx_ready;
		line_state[urf_pkg::LS_OVERRUN] = overrun_q;
		line_state[urf_pkg::LS_PARITY +: 3] = head_tags;
		line_state[urf_pkg::LS_HOLD_EMPTY] = hold_empty;
		line_state[urf_pkg::LS_ALL_EMPTY] = all_empty;
	end

	wire [31:0] rd_mux =
		hit_data ? {24'h0, rx_ready ? rxf.rdata[7:0] : 8'h00} :
		hit_ien ? {29'h0, interrupt_enable_reg_q} :
		hit_icause ? {29'h0, interrupt_cause_q} :
		hit_fctl ? {27'h0, fifo_control_q} :
		hit_lfmt ? {27'h0, line_format_control_q} :
		hit_lstate ? {24'h0, line_state} :
		hit_fdiv ? {26'h0, os_sel_q, 4'h0} :
		hit_bdiv ? {16'h0, baud_div_q} : 32'h0;

	// Transmit data path
	wire tx_load = (tx_state_q == urf_pkg::ST_IDLE) && !hold_empty;
	wire tx_bit_end = os_tick && (tx_sub_q == bit_len - 5'h01);
	wire fifo_mode_flip = wr && hit_fctl && (pwdata[urf_pkg::FC_FIFO_EN] != fifo_en);
	assign txf.push = wr && hit_data && (txf.count < fill_limit);
	assign txf.wdata = pwdata[7:0];
	assign txf.pop = tx_load;
	assign txf.flush = fifo_mode_flip;
	wire tx_parity_calc = (^(txf.rdata & wmask)) ^ ~par_even;

	// Holding empty in non-FIFO mode, or fill dropping below trigger in FIFO mode
	wire [5:0] tx_edge = fifo_en ? urf_pkg::trig_level(tx_trig_sel) : 6'h01;
	wire tx_evt = tx_load && (txf.count == tx_edge);

	// Receive data path; samples take the second synchroniser stage, the start edge the second and third
	wire rx_fall = rx_s3_q && !rx_s2_q;
	wire rx_sample = os_tick && (rx_sub_q == bit_len - 5'h01);
	wire rx_start_mid = os_tick && (rx_sub_q == half_len - 5'h01);
	wire [7:0] rx_data = (rx_shifter_q >> (2'h3 - wsel)) & wmask;
	wire rx_par_bad = rx_s2_q ^ ((^rx_data) ^ ~par_even);
	wire rx_stop_done = (rx_state_q == urf_pkg::ST_STOP) && rx_sample;
	wire rx_full = (rxf.count >= fill_limit);
	wire rx_frame_err = !rx_s2_q;
	wire rx_break = rx_frame_err && (rx_data == 8'h00);
	assign rxf.push = rx_stop_done && !rx_full;
	assign rxf.wdata = {rx_break, rx_frame_err, rx_perr_q, rx_data};
	assign rxf.pop = rd && hit_data && rx_ready;
	assign rxf.flush = fifo_mode_flip;
	wire [5:0] rx_edge = fifo_en ? urf_pkg::trig_level(rx_trig_sel) - 6'h01 : 6'h00;
	wire rx_evt = rxf.push && (rxf.count == rx_edge);

	// Time-out after silence with data waiting
	wire [5:0] to_limit = 6'(urf_pkg::TO_WORDS * 6'(4'(wsel) + urf_pkg::WLEN_BASE) + urf_pkg::TO_EXTRA);
	wire to_restart = rxf.push || rxf.pop || !rx_ready;
	wire to_bit_end = os_tick && (to_sub_q == bit_len - 5'h01);
	wire to_evt = !to_restart && !to_done_q && to_bit_end && (to_bits_q == to_limit - 6'h01);

	// Sticky causes; a new event wins over a same-cycle write of one
	wire [2:0] cause_clr = (wr && hit_icause) ? pwdata[2:0] : 3'h0;
	assign interrupt_cause_d = (interrupt_cause_q & ~cause_clr) | {to_evt, tx_evt, rx_evt};
	// Receive and time-out causes share the receive enable bit
	wire [2:0] cause_mask = {interrupt_enable_reg_q[urf_pkg::IC_RX], interrupt_enable_reg_q[urf_pkg::IC_TX],
		interrupt_enable_reg_q[urf_pkg::IC_RX]};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
			interrupt_cause_q <= 3'h0;
			overrun_q <= 1'b0;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pready_d && !mapped;
			prdata_q <= (pready_d && !pwrite) ? rd_mux : 32'h0;
			interrupt_cause_q <= interrupt_cause_d;
			irq_q <= |(interrupt_cause_q & cause_mask);
			overrun_q <= (rx_stop_done && rx_full) || (overrun_q && !(rd && hit_lstate));
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_control_q <= urf_pkg::RST_FIFO_CTL;
			line_format_control_q <= urf_pkg::RST_LINE_FMT;
			os_sel_q <= urf_pkg::RST_OS_SEL;
			baud_div_q <= urf_pkg::RST_BAUD_DIV;
			interrupt_enable_reg_q <= urf_pkg::RST_INT_ENABLE;
		end
		else if (wr)
		begin
			if (hit_fctl)
				fifo_control_q <= pwdata[4:0];
			if (hit_lfmt)
				line_format_control_q <= pwdata[4:0];
			if (hit_fdiv)
				os_sel_q <= pwdata[urf_pkg::FD_OS_LSB +: 2];
			if (hit_bdiv)
				baud_div_q <= pwdata[15:0];
			if (hit_ien)
				interrupt_enable_reg_q <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_q <= 16'h0;
		else
			div_cnt_q <= os_tick ? 16'h0 : div_cnt_q + 16'h1;
	end

	// Transmitter sequencing; a bit ends every bit_len ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state_q <= urf_pkg::ST_IDLE;
			tx_shifter_q <= 8'h00;
			tx_bit_q <= 3'h0;
			tx_sub_q <= 5'h00;
			tx_parity_q <= 1'b0;
			tx_stop2_q <= 1'b0;
			txd_q <= 1'b1;
		end
		else
		begin
			if (tx_state_q != urf_pkg::ST_IDLE && os_tick)
				tx_sub_q <= tx_bit_end ? 5'h00 : tx_sub_q + 5'h01;
			case (tx_state_q)
				urf_pkg::ST_IDLE:
					if (tx_load)
					begin
						tx_shifter_q <= txf.rdata;
						tx_parity_q <= tx_parity_calc;
						tx_sub_q <= 5'h00;
						txd_q <= 1'b0;
						tx_state_q <= urf_pkg::ST_START;
					end
				urf_pkg::ST_START:
					if (tx_bit_end)
					begin
						txd_q <= tx_shifter_q[0];
						tx_shifter_q <= tx_shifter_q >> 1;
						tx_bit_q <= 3'h0;
						tx_state_q <= urf_pkg::ST_DATA;
					end
				urf_pkg::ST_DATA:
					if (tx_bit_end)
					begin
						if (tx_bit_q == last_bit)
						begin
							txd_q <= par_en ? tx_parity_q : 1'b1;
							tx_stop2_q <= stop2;
							tx_state_q <= par_en ? urf_pkg::ST_PARITY : urf_pkg::ST_STOP;
						end
						else
						begin
							txd_q <= tx_shifter_q[0];
							tx_shifter_q <= tx_shifter_q >> 1;
							tx_bit_q <= tx_bit_q + 3'h1;
						end
					end
				urf_pkg::ST_PARITY:
					if (tx_bit_end)
					begin
						txd_q <= 1'b1;
						tx_state_q <= urf_pkg::ST_STOP;
					end
				urf_pkg::ST_STOP:
					if (tx_bit_end)
					begin
						if (tx_stop2_q)
							tx_stop2_q <= 1'b0;
						else
							tx_state_q <= urf_pkg::ST_IDLE;
					end
				default:
				begin
					txd_q <= 1'b1;
					tx_state_q <= urf_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Receive pin synchroniser and edge history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	// Receiver: after the start centre, every later sample is one whole bit apart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_state_q <= urf_pkg::ST_IDLE;
			rx_shifter_q <= 8'h00;
			rx_bit_q <= 3'h0;
			rx_sub_q <= 5'h00;
			rx_perr_q <= 1'b0;
		end
		else
		begin
			case (rx_state_q)
				urf_pkg::ST_IDLE:
					if (rx_fall)
					begin
						rx_sub_q <= 5'h00;
						rx_perr_q <= 1'b0;
						rx_state_q <= urf_pkg::ST_START;
					end
				urf_pkg::ST_START:
					if (rx_start_mid)
					begin
						rx_sub_q <= 5'h00;
						rx_bit_q <= 3'h0;
						// A glitch shorter than half a bit is dropped here
						rx_state_q <= rx_s2_q ? urf_pkg::ST_IDLE : urf_pkg::ST_DATA;
					end
					else if (os_tick)
						rx_sub_q <= rx_sub_q + 5'h01;
				urf_pkg::ST_DATA:
					if (rx_sample)
					begin
						rx_sub_q <= 5'h00;
						rx_shifter_q <= {rx_s2_q, rx_shifter_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == last_bit)
							rx_state_q <= par_en ? urf_pkg::ST_PARITY : urf_pkg::ST_STOP;
					end
					else if (os_tick)
						rx_sub_q <= rx_sub_q + 5'h01;
				urf_pkg::ST_PARITY:
					if (rx_sample)
					begin
						rx_sub_q <= 5'h00;
						rx_perr_q <= rx_par_bad;
						rx_state_q <= urf_pkg::ST_STOP;
					end
					else if (os_tick)
						rx_sub_q <= rx_sub_q + 5'h01;
				urf_pkg::ST_STOP:
					if (rx_sample)
						rx_state_q <= urf_pkg::ST_IDLE;
					else if (os_tick)
						rx_sub_q <= rx_sub_q + 5'h01;
				default:
					rx_state_q <= urf_pkg::ST_IDLE;
			endcase
		end
	end

	// Silence timer counts bit times while data waits unread
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_sub_q <= 5'h00;
			to_bits_q <= 6'h00;
			to_done_q <= 1'b0;
		end
		else if (to_restart)
		begin
			to_sub_q <= 5'h00;
			to_bits_q <= 6'h00;
			to_done_q <= 1'b0;
		end
		else if (os_tick && !to_done_q)
		begin
			to_sub_q <= to_bit_end ? 5'h00 : to_sub_q + 5'h01;
			if (to_bit_end)
				to_bits_q <= to_bits_q + 6'h01;
			if (to_evt)
				to_done_q <= 1'b1;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txd = txd_q;
	assign irq = irq_q;
endmodule : urf_uart

// ==== dv/urf_peer.sv ====
/*
 * Serial peer: drives frames onto rxd and captures frames from txd.
 * Assumes the caller gives the bit length in pclk cycles.
 */
`timescale 1ns/100ps
module urf_peer
(
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	// Mark level while no frame is sent
	initial rxd = 1'b1;

	task automatic send(input logic [11:0] f, input int n, input int bl);
		for (int i = 0; i < n; i++)
		begin
			rxd <= f[i];
			repeat (bl) @(posedge pclk);
		end
		rxd <= 1'b1;
	endtask : send

	// Returns at the last stop centre so a following start edge is not missed
	task automatic recv(input int n, input int bl, output logic [11:0] f);
		int k;
		f = '1;
		k = 0;
		while (txd !== 1'b0 && k < 4000)
		begin
			@(posedge pclk);
			k++;
		end
		// A silent line ends the run rather than framing garbage
		if (k >= 4000)
		begin
			tb_top.n_fail++;
			tb_top.report_and_stop();
		end
		repeat (bl / 2) @(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			f[i] = txd;
			if (i < n - 1)
				repeat (bl) @(posedge pclk);
		end
	endtask : recv
endmodule : urf_peer

// ==== dv/urf_uart_props.sv ====
/*
 * Assertions on the ports of the serial channel.
 * Assumes it is bound to urf_uart and sees only its ports.
 */
`timescale 1ns/100ps
module urf_uart_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxd,
	input wire logic txd,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic bad_addr;
	assign bad_addr = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);

	sequence setup_s;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence one_wait_s;
		!pready ##1 pready;
	endsequence

	apb_answer_a: assert property (setup_s |-> one_wait_s)
		else $error("pready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	addr_decode_a: assert property (pready |-> pslverr == bad_addr)
		else $error("pslverr does not match address map");
	rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata nonzero outside read completion");
	err_rdata_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("unmapped read returned data");
	reset_idle_a: assert property ($rose(presetn) |-> txd && !irq)
		else $error("txd or irq wrong after reset");
	start_min_a: assert property ($fell(txd) |-> !txd [*3])
		else $error("start bit too short");
endmodule : urf_uart_props

bind urf_uart urf_uart_props u_urf_uart_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .irq);

// ==== dv/tb_top.sv ====
/*
 * Self-checking bench for urf_uart with a serial peer on both pins.
 * Assumes baud divisor 0, so one oversampling tick per clock.
 */
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] DT = urf_pkg::OFS_DATA;
	localparam logic [7:0] IE = urf_pkg::OFS_INT_ENABLE;
	localparam logic [7:0] IC = urf_pkg::OFS_INT_CAUSE;
	localparam logic [7:0] FC = urf_pkg::OFS_FIFO_CTL;
	localparam logic [7:0] LF = urf_pkg::OFS_LINE_FMT;
	localparam logic [7:0] LS = urf_pkg::OFS_LINE_STATE;
	localparam logic [7:0] FD = urf_pkg::OFS_FRAC_DIV;
	localparam logic [7:0] BD = urf_pkg::OFS_BAUD_DIV;
	logic pclk, presetn, psel, penable, pwrite, rxd, txd, irq, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [11:0] f, g;
	int n_fail, comparisons;

	urf_uart u_urf_uart (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .txd, .irq);
	urf_peer u_urf_peer (.pclk, .txd, .rxd);

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic report_and_stop;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// Idle cycle at the end so back-to-back calls never drive psel twice in one step
	task automatic apb(input logic [31:0] w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				n_fail++;
				report_and_stop();
			end
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Frame bits in line order: start, data LSB first, parity, stops
	function automatic logic [11:0] mk(input logic [7:0] d, input logic [4:0] m, input logic pe,
		input logic fe, output int n);
		int w;
		logic p;
		w = 5 + m[1:0];
		mk = 12'hFFF;
		mk[0] = 1'b0;
		p = ~m[4];
		for (int i = 0; i < w; i++)
		begin
			mk[i + 1] = d[i];
			p ^= d[i];
		end
		n = w + 2 + m[2] + m[3];
		if (m[3])
			mk[w + 1] = p ^ pe;
		mk[w + 1 + m[3]] = ~fe;
	endfunction : mk

	function automatic logic [31:0] tagx(input logic [7:0] d, input logic [4:0] m, input logic pe,
		input logic fe);
		tagx = {27'h0, fe && ((d & (8'hFF >> (3 - m[1:0]))) == 8'h0), fe, pe && m[3], 2'h0};
	endfunction : tagx

	initial
	begin
		#400000;
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		logic [7:0] d;
		logic [7:0] q [32];
		logic [4:0] m;
		logic pe, fe;
		int n, bl;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_fail = 0;
		comparisons = 0;
		void'($urandom(32'hC9D0997A));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, FC, 0);
		chk("fifo_control reset", r, 32'h0);
		apb(0, LF, 0);
		chk("line_format reset", r, 32'h3);
		apb(0, LS, 0);
		chk("line_state reset", r, 32'h60);
		apb(0, 8'h20, 0);
		chk("unmapped err", e, 1'b1);
		apb(1, BD, 0);
		// Every line format, the three rates, clean and faulty frames
		for (int i = 0; i < 32; i++)
		begin
			m = 5'(i);
			bl = 16 >> (i % 3);
			d = 8'($urandom);
			pe = (i % 3 == 1);
			fe = (i % 3 == 2);
			apb(1, FD, (i % 3) << 4);
			apb(1, LF, m);
			g = mk(d, m, 1'b0, 1'b0, n);
			fork
				apb(1, DT, d);
				u_urf_peer.recv(n, bl, f);
			join
			chk("tx frame", f, g);
			g = mk(d, m, pe, fe, n);
			u_urf_peer.send(g, n, bl);
			repeat (bl) @(posedge pclk);
			apb(0, LS, 0);
			chk("rx line_state", r, 32'h61 | tagx(d, m, pe, fe));
			apb(0, DT, 0);
			chk("receive_holding", r, d & (8'hFF >> (3 - m[1:0])));
			apb(0, LS, 0);
			chk("line_state emptied", r, 32'h60);
		end
		apb(1, FD, 32'h20);
		apb(1, LF, 32'h3);
		u_urf_peer.send(12'h0, 1, 1);
		repeat (60) @(posedge pclk);
		apb(0, LS, 0);
		chk("false start", r, 32'h60);
		// Second byte arrives while the single non-FIFO slot is still full
		g = mk(8'hA5, 5'h03, 1'b0, 1'b0, n);
		for (int j = 0; j < 2; j++)
		begin
			u_urf_peer.send(g, n, 4);
			repeat (4) @(posedge pclk);
		end
		apb(0, LS, 0);
		chk("overrun set", r, 32'h63);
		apb(0, LS, 0);
		chk("overrun cleared", r, 32'h61);
		apb(0, DT, 0);
		chk("first byte kept", r, 32'hA5);
		apb(1, IC, 7);
		apb(1, DT, $urandom);
		apb(0, IC, 0);
		chk("tx cause", r, 32'h2);
		chk("masked irq", irq, 1'b0);
		apb(0, LS, 0);
		chk("shifter busy", r, 32'h20);
		apb(1, IE, 2);
		apb(0, LS, 0);
		chk("tx irq", irq, 1'b1);
		apb(1, IC, 2);
		apb(0, IC, 0);
		chk("cause cleared", r, 32'h0);
		chk("irq cleared", irq, 1'b0);
		repeat (60) @(posedge pclk);
		apb(1, IE, 0);
		apb(1, FC, 1);
		apb(1, IC, 7);
		fork
			begin
				for (int j = 0; j < 32; j++)
				begin
					q[j] = 8'($urandom);
					apb(1, DT, q[j]);
				end
				apb(0, LS, 0);
				chk("fifo busy", r[6:5], 2'h0);
			end
			for (int j = 0; j < 32; j++)
			begin
				u_urf_peer.recv(10, 4, f);
				chk("fifo tx", f, mk(q[j], 5'h03, 1'b0, 1'b0, n));
			end
		join
		repeat (8) @(posedge pclk);
		apb(0, LS, 0);
		chk("fifo drained", r, 32'h60);
		apb(0, IC, 0);
		chk("tx trigger", r[1], 1'b1);
		apb(1, IC, 7);
		apb(1, IE, 1);
		for (int j = 0; j < 8; j++)
		begin
			q[j] = 8'($urandom);
			g = mk(q[j], 5'h03, 1'b0, j == 2, n);
			u_urf_peer.send(g, n, 4);
			repeat (4) @(posedge pclk);
			if (j == 6)
			begin
				apb(0, IC, 0);
				chk("below rx trigger", r, 32'h0);
			end
		end
		apb(0, IC, 0);
		chk("rx trigger", r, 32'h1);
		chk("rx irq", irq, 1'b1);
		apb(1, IC, 1);
		repeat (120) @(posedge pclk);
		apb(0, IC, 0);
		chk("no timeout yet", r, 32'h0);
		repeat (60) @(posedge pclk);
		apb(0, IC, 0);
		chk("timeout", r, 32'h4);
		for (int j = 0; j < 8; j++)
		begin
			apb(0, LS, 0);
			chk("head tags", r & 32'h1C, tagx(q[j], 5'h03, 1'b0, j == 2));
			apb(0, DT, 0);
			chk("rx fifo data", r, q[j]);
		end
		report_and_stop();
	end
endmodule : tb_top
